// [rtl/limo_core.sv]
// Move-op execution core with an APB register port.
// Functional notes
// - Load-bank-literal puts 5-bit literal into bank select, no flags.
// - Load-page-latch-literal puts 7-bit literal into the pc high latch.
// - Load-work-literal puts 8-bit literal into the working register.
// - Store-work-to-file writes working register to bank select plus 7-bit file address.
// - Indirect store writes working register where pointer 0/1 points.
// - Mode field: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Relative form addresses pointer plus signed -32..31, keeps pointer.
// - Increment modes leave pointer one higher, decrement modes one lower.
// - Pointer is 16 bits and wraps modulo 10000h.
// - Pointer updates and indirect store change no status bit.
// - Software reset resets device and clears reset-instruction flag.
// - Return-from-interrupt pops stack top to pc, sets enable, two cycles.
`timescale 1ns/1ns
module limo_core
  import limo_pkg::*;
(
  // Clock and reset.
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  // APB slave.
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // Data memory write port.
  output limo_file_wr_type      FILE_WRITE,
  // Return stack.
  input  wire logic [14:0]      STACK_TOP,
  output logic                  STACK_POP,
  // Device reset request.
  output logic                  SOFT_RESET
);

  limo_state_type   state;
  limo_state_type   next_state;
  limo_core_type    core;
  limo_core_type    next_core;
  limo_file_wr_type next_wr;
  logic [13:0]      instr;
  logic [13:0]      next_instr;
  logic             ri;
  logic             next_ri;
  logic             next_soft;
  logic             next_pop;
  logic             was_idle;
  logic [31:0]      next_prdata;
  logic [31:0]      rd_value;
  logic             mapped;
  logic             exec;
  logic             is_lb, is_lp, is_lw, is_wf, is_wi, is_wir;
  logic             is_nop, is_rst, is_rfie;
  logic             use_fsr1;
  logic [15:0]      fsel;
  logic [15:0]      eff_addr;
  logic [15:0]      new_fsel;
  logic [15:0]      rel_offset;

  assign exec    = (state == ST_EXEC);
  assign is_lb   = (instr & MASK_LB)  == PAT_LB;
  assign is_lp   = (instr & MASK_LP)  == PAT_LP;
  assign is_lw   = (instr & MASK_LW)  == PAT_LW;
  assign is_wf   = (instr & MASK_WF)  == PAT_WF;
  assign is_wi   = (instr & MASK_WI)  == PAT_WI;
  assign is_wir  = (instr & MASK_WIR) == PAT_WIR;
  assign is_nop  = instr == OP_NOP;
  assign is_rst  = instr == OP_RESET;
  assign is_rfie = instr == OP_RETURN_FROM_INTERRUPT_OP;

  // Waiting one idle cycle lets PRDATA be captured after the last update.
  assign PREADY  = PENABLE && (state == ST_IDLE) && was_idle;
  assign PSLVERR = PSEL && PENABLE && PREADY && !mapped;

  // Pointer arithmetic is plain 16-bit, so wrap comes for free.
  always_comb begin
    use_fsr1   = is_wir ? instr[REL_SEL_BIT] : instr[FSEL_BIT];
    fsel       = use_fsr1 ? core.fsr1 : core.fsr0;
    rel_offset = {{10{instr[5]}}, instr[5:0]};
    eff_addr   = fsel;
    new_fsel   = fsel;
    if (is_wir) begin
      eff_addr = fsel + rel_offset;
    end else begin
      unique case (limo_mode_type'(instr[1:0]))
        MODE_PRE_INC: begin
          eff_addr = fsel + 16'h0001;
          new_fsel = fsel + 16'h0001;
        end
        MODE_PRE_DEC: begin
          eff_addr = fsel - 16'h0001;
          new_fsel = fsel - 16'h0001;
        end
        MODE_POST_INC: new_fsel = fsel + 16'h0001;
        MODE_POST_DEC: new_fsel = fsel - 16'h0001;
      endcase
    end
  end

  always_comb begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (PADDR)
      ADDR_INSTR:  rd_value[13:0] = instr;
      ADDR_WORK:   rd_value[7:0]  = core.work;
      ADDR_BANK:   rd_value[4:0]  = core.bank_select_reg;
      ADDR_LATCH:  rd_value[6:0]  = core.pc_high_latch;
      ADDR_FSEL0:  rd_value[15:0] = core.fsr0;
      ADDR_FSEL1:  rd_value[15:0] = core.fsr1;
      ADDR_PC:     rd_value[14:0] = core.pc;
      ADDR_STATUS: rd_value[7:0]  = core.status;
      ADDR_POWER:  rd_value[RI_BIT]  = ri;
      ADDR_INTCTL: rd_value[GIE_BIT] = core.global_irq_enable;
      ADDR_BUSY:   rd_value[0]    = (state != ST_IDLE);
      default:     mapped = 1'b0;
    endcase
    next_prdata = PSEL ? rd_value : PRDATA;
  end

  always_comb begin
    next_state = state;
    next_core  = core;
    next_instr = instr;
    next_ri    = ri;
    next_soft  = 1'b0;
    next_pop   = 1'b0;
    next_wr    = '{en: 1'b0, addr: 16'h0000, data: 8'h00};
    if (PSEL && PENABLE && PWRITE && PREADY) begin
      unique case (PADDR)
        ADDR_INSTR: begin
          next_instr = PWDATA[13:0];
          next_state = ST_EXEC;
        end
        ADDR_WORK:   next_core.work   = PWDATA[7:0];
        ADDR_BANK:   next_core.bank_select_reg    = PWDATA[4:0];
        ADDR_LATCH:  next_core.pc_high_latch = PWDATA[6:0];
        ADDR_FSEL0:  next_core.fsr0   = PWDATA[15:0];
        ADDR_FSEL1:  next_core.fsr1   = PWDATA[15:0];
        ADDR_PC:     next_core.pc     = PWDATA[14:0];
        ADDR_STATUS: next_core.status = PWDATA[7:0];
        ADDR_POWER:  next_ri          = PWDATA[RI_BIT];
        ADDR_INTCTL: next_core.global_irq_enable    = PWDATA[GIE_BIT];
        default: ;
      endcase
    end
    unique case (state)
      ST_IDLE: ;
      ST_EXEC: begin
        next_state   = ST_IDLE;
        next_core.pc = core.pc + 15'h0001;
        if (is_lb) begin
          next_core.bank_select_reg = instr[4:0];
        end else if (is_lp) begin
          next_core.pc_high_latch = instr[6:0];
        end else if (is_lw) begin
          next_core.work = instr[7:0];
        end else if (is_wf) begin
          next_wr = '{en: 1'b1, addr: {4'h0, core.bank_select_reg, instr[6:0]},
                      data: core.work};
        end else if (is_wi || is_wir) begin
          next_wr = '{en: 1'b1, addr: eff_addr,
                      data: core.work};
          if (use_fsr1) begin
            next_core.fsr1 = new_fsel;
          end else begin
            next_core.fsr0 = new_fsel;
          end
        end else if (is_rst) begin
          next_core = CORE_RESET;
          next_ri   = 1'b0;
          next_soft = 1'b1;
        end else if (is_rfie) begin
          next_core.pc  = STACK_TOP;
          next_core.global_irq_enable = 1'b1;
          next_pop      = 1'b1;
          next_state    = ST_RET2;
        end
      end
      ST_RET2: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_IDLE;
      core       <= CORE_RESET;
      instr      <= INSTR_RESET;
      ri         <= RI_RESET;
      SOFT_RESET <= 1'b0;
      STACK_POP  <= 1'b0;
      FILE_WRITE <= '{en: 1'b0, addr: 16'h0000, data: 8'h00};
      was_idle   <= 1'b1;
      PRDATA     <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      core       <= next_core;
      instr      <= next_instr;
      ri         <= next_ri;
      SOFT_RESET <= next_soft;
      STACK_POP  <= next_pop;
      FILE_WRITE <= next_wr;
      was_idle   <= (state == ST_IDLE);
      PRDATA     <= next_prdata;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rfie_issue;
    exec && is_rfie;
  endsequence

  sequence s_rfie_done;
    (state == ST_RET2) && core.global_irq_enable && STACK_POP ##1 (state == ST_IDLE);
  endsequence

  chk_bank_load: assert property (exec && is_lb |=>
    core.bank_select_reg == $past(instr[4:0]) && core.status == $past(core.status))
    else $error("bank select not loaded from literal");
  chk_latch_load: assert property (exec && is_lp |=>
    core.pc_high_latch == $past(instr[6:0]))
    else $error("pc high latch not loaded from literal");
  chk_work_load: assert property (exec && is_lw |=>
    core.work == $past(instr[7:0]))
    else $error("working register not loaded from literal");
  chk_file_store: assert property (exec && is_wf |=>
    FILE_WRITE.en && FILE_WRITE.data == $past(core.work)
    && FILE_WRITE.addr[6:0] == $past(instr[6:0]))
    else $error("file store wrong");
  chk_indirect_data: assert property (
    exec && (is_wi || is_wir) |=>
    FILE_WRITE.en && FILE_WRITE.data == $past(core.work))
    else $error("indirect store data wrong");
  chk_pre_inc_addr: assert property (
    exec && is_wi && instr[1:0] == 2'b00 |=>
    FILE_WRITE.addr == $past(fsel) + 16'h0001)
    else $error("pre-increment address wrong");
  chk_rel_keep: assert property (exec && is_wir |=>
    core.fsr0 == $past(core.fsr0) && core.fsr1 == $past(core.fsr1))
    else $error("relative form changed a pointer");
  chk_post_dec_wrap: assert property (
    exec && is_wi && instr[1:0] == 2'b11
    && !instr[FSEL_BIT] && core.fsr0 == 16'h0000 |=> core.fsr0 == 16'hFFFF)
    else $error("post-decrement did not wrap");
  chk_status_keep: assert property (exec |=>
    core.status == $past(core.status) || $past(is_rst))
    else $error("status changed by move op");
  chk_soft_reset: assert property (exec && is_rst |=>
    SOFT_RESET && !ri && core == CORE_RESET)
    else $error("software reset incomplete");
  chk_rfie_two: assert property (s_rfie_issue |=> s_rfie_done)
    else $error("return from interrupt sequence wrong");
  chk_nop_only_pc: assert property (exec && is_nop |=>
    core.pc == $past(core.pc) + 15'h0001 && core.work == $past(core.work)
    && !FILE_WRITE.en && state == ST_IDLE)
    else $error("nop changed more than pc");

endmodule : limo_core

// [rtl/limo_pkg.sv]
// Constants, opcodes, register map and carrier types of the move-op core.
package limo_pkg;

  // Register offsets on the APB bus (byte addresses).
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_WORK   = 8'h04;
  localparam logic [7:0] ADDR_BANK   = 8'h08;
  localparam logic [7:0] ADDR_LATCH  = 8'h0C;
  localparam logic [7:0] ADDR_FSEL0  = 8'h10;
  localparam logic [7:0] ADDR_FSEL1  = 8'h14;
  localparam logic [7:0] ADDR_PC     = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_POWER  = 8'h20;
  localparam logic [7:0] ADDR_INTCTL = 8'h24;
  localparam logic [7:0] ADDR_BUSY   = 8'h28;

  // Field positions.
  localparam int unsigned RI_BIT      = 2;
  localparam int unsigned GIE_BIT     = 7;
  localparam int unsigned FSEL_BIT    = 2;
  localparam int unsigned REL_SEL_BIT = 6;

  // Opcodes: exact words, and pattern/mask pairs for literal, file-store and indirect-store forms.
  localparam logic [13:0] OP_NOP     = 14'h0000;
  localparam logic [13:0] OP_RESET   = 14'h0001;
  localparam logic [13:0] OP_RETURN_FROM_INTERRUPT_OP  = 14'h0009;
  localparam logic [13:0] MASK_LB    = 14'h3FE0;
  localparam logic [13:0] PAT_LB     = 14'h0020;
  localparam logic [13:0] MASK_LP    = 14'h3F80;
  localparam logic [13:0] PAT_LP     = 14'h3180;
  localparam logic [13:0] MASK_LW    = 14'h3F00;
  localparam logic [13:0] PAT_LW     = 14'h3000;
  localparam logic [13:0] MASK_WF    = 14'h3F80;
  localparam logic [13:0] PAT_WF     = 14'h0080;
  localparam logic [13:0] MASK_WI    = 14'h3FF8;
  localparam logic [13:0] PAT_WI     = 14'h0018;
  localparam logic [13:0] MASK_WIR   = 14'h3F80;
  localparam logic [13:0] PAT_WIR    = 14'h3F80;

  // Reset values.
  localparam logic        RI_RESET   = 1'b1;
  localparam logic [13:0] INSTR_RESET = 14'h0000;

  typedef enum logic [1:0] {
    MODE_PRE_INC  = 2'b00,
    MODE_PRE_DEC  = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } limo_mode_type;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2} limo_state_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } limo_file_wr_type;

  typedef struct packed {
    logic [7:0]  work;
    logic [4:0]  bank_select_reg;
    logic [6:0]  pc_high_latch;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [14:0] pc;
    logic [7:0]  status;
    logic        global_irq_enable;
  } limo_core_type;

  localparam limo_core_type CORE_RESET = '{
    work: 8'h00, bank_select_reg: 5'h00, pc_high_latch: 7'h00, fsr0: 16'h0000,
    fsr1: 16'h0000, pc: 15'h0000, status: 8'h00, global_irq_enable: 1'b0};

endpackage : limo_pkg

// [test/tb_limo_core.sv]
// Self-checking bench for the move-op core, driven over APB.
`timescale 1ns/1ns
module tb_limo_core;
  import limo_pkg::*;
  logic             CLK = 1'b0;
  logic             RESET_N = 1'b0;
  logic             PSEL = 1'b0;
  logic             PENABLE = 1'b0;
  logic             PWRITE = 1'b0;
  logic [7:0]       PADDR = 8'h00;
  logic [31:0]      PWDATA = 32'h0;
  logic [31:0]      PRDATA;
  logic             PREADY;
  logic             PSLVERR;
  limo_file_wr_type FILE_WRITE;
  logic [14:0]      STACK_TOP = 15'h1234;
  logic             STACK_POP;
  logic             SOFT_RESET;
  int               num_errors = 0;
  int               comparisons = 0;
  int               n_wr = 0;
  int               n_pop = 0;
  int               n_rst = 0;
  limo_file_wr_type seen;
  logic [31:0]      q;
  logic             er;
  logic [15:0]      p;
  logic [15:0]      ea;
  logic [15:0]      np;
  logic [7:0]       fa;
  logic [14:0]      pc0;
  always #50 CLK = ~CLK;
  limo_core limo_core_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FILE_WRITE(FILE_WRITE), .STACK_TOP(STACK_TOP), .STACK_POP(STACK_POP),
    .SOFT_RESET(SOFT_RESET));
  // Pulses last one cycle, so they are counted rather than polled.
  always @(posedge CLK) begin
    if (FILE_WRITE.en === 1'b1) begin
      seen = FILE_WRITE;
      n_wr++;
    end
    if (STACK_POP === 1'b1) n_pop++;
    if (SOFT_RESET === 1'b1) n_rst++;
  end
  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    q  = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("Error pready expected 1 seen timeout");
      wrap_up();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task automatic op(input logic [13:0] o);
    apb(1'b1, ADDR_INSTR, {18'h0, o});
  endtask : op
  initial begin
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(ADDR_POWER, "ri_reset", 32'h4);
    apb(1'b1, ADDR_STATUS, 32'hA5);
    op(PAT_LB | 14'h1F);
    rd(ADDR_BANK, "bank", 32'h1F);
    op(PAT_LP | 14'h7F);
    rd(ADDR_LATCH, "latch", 32'h7F);
    op(PAT_LW | 14'hFF);
    rd(ADDR_WORK, "work_ff", 32'hFF);
    op(PAT_LW | 14'h5A);
    op(PAT_WF | 14'h7F);
    rd(ADDR_WORK, "work_5a", 32'h5A);
    chk("wf_addr", 32'h0FFF, {16'h0, seen.addr});
    chk("wf_data", 32'h5A, {24'h0, seen.data});
    // Increments start at the top and decrements at zero to force a wrap.
    for (int i = 0; i < 8; i++) begin
      fa = (i >= 4) ? ADDR_FSEL1 : ADDR_FSEL0;
      p  = i[0] ? 16'h0000 : 16'hFFFF;
      apb(1'b1, fa, {16'h0, p});
      op(PAT_WI | 14'(i));
      ea = i[1] ? p : (i[0] ? p - 16'h1 : p + 16'h1);
      np = i[0] ? p - 16'h1 : p + 16'h1;
      rd(fa, "ptr", {16'h0, np});
      chk("wi_addr", {16'h0, ea}, {16'h0, seen.addr});
      chk("wi_data", 32'h5A, {24'h0, seen.data});
      chk("wi_count", 32'(i + 2), 32'(n_wr));
    end
    apb(1'b1, ADDR_FSEL0, 32'h0010);
    op(PAT_WIR | 14'h20);
    rd(ADDR_FSEL0, "rel_ptr0", 32'h0010);
    chk("rel_addr0", 32'hFFF0, {16'h0, seen.addr});
    apb(1'b1, ADDR_FSEL1, 32'hFFF0);
    op(PAT_WIR | 14'h5F);
    rd(ADDR_FSEL1, "rel_ptr1", 32'hFFF0);
    chk("rel_addr1", 32'h000F, {16'h0, seen.addr});
    rd(ADDR_STATUS, "status", 32'hA5);
    apb(1'b0, ADDR_PC, 32'h0);
    pc0 = q[14:0];
    op(OP_NOP);
    rd(ADDR_PC, "nop_pc", {17'h0, pc0 + 15'h1});
    rd(ADDR_WORK, "nop_work", 32'h5A);
    chk("nop_count", 32'd11, 32'(n_wr));
    op(OP_RETURN_FROM_INTERRUPT_OP);
    rd(ADDR_PC, "ret_pc", 32'h1234);
    rd(ADDR_INTCTL, "ret_gie", 32'h80);
    chk("ret_pop", 32'd1, 32'(n_pop));
    op(OP_RESET);
    rd(ADDR_POWER, "ri_clear", 32'h0);
    rd(ADDR_WORK, "rst_work", 32'h0);
    chk("rst_pulse", 32'd1, 32'(n_rst));
    apb(1'b0, 8'h2C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, q);
    wrap_up();
  end
endmodule : tb_limo_core
